// File: design/enc_ctl_defines.svh
`ifndef ENC_CTL_DEFINES_SVH
`define ENC_CTL_DEFINES_SVH

// Device bus addresses, 8-bit form with direction bit
`define DEV_ADDR_W       8'h88
`define DEV_ADDR_R       8'h89

// Device subaddresses
`define SUB_LINE_COUNT   8'hD0
`define SUB_LINE_TYPE    8'hD1
`define SUB_LINE_PAT     8'hD2
`define SUB_VALUE_ARR    8'hD3
`define SUB_COLOUR       8'hFF
`define SUB_CURSOR       8'hFE
`define SUB_PWR          8'h60
`define SUB_FIC          8'h61

// Bit positions inside the device power and input-cell bytes
`define PWR_ANALOG_BIT   6
`define PWR_DIGITAL_BIT  7
`define FIC_BIT          0

// Bytes per table entry, pointer byte excluded
`define ENT_COLOUR       4'h3
`define ENT_CURSOR       4'h1
`define ENT_COUNT        4'h2
`define ENT_TYPE         4'h4
`define ENT_PAT          4'h8
`define ENT_VALUE        4'h2

// Software register map
`define REG_CMD          4'h0
`define REG_SUB          4'h1
`define REG_LEN          4'h2
`define REG_STATUS       4'h3
`define REG_BUF_IDX      4'h4
`define REG_BUF_DATA     4'h5
`define REG_FIC          4'h6
`define REG_PWR          4'h7

// Command bits
`define CMD_WR           0
`define CMD_RD           1
`define CMD_PD           2
`define CMD_PU           3

// Status bits
`define ST_BUSY          0
`define ST_NACK          1
`define ST_REFUSED       2
`define ST_TYPE_STALE    3
`define ST_REINIT        4
`define ST_PD            5
`define ST_PAT_LOADED    6

// Transfer buffer
`define BUF_DEPTH        32
`define BUF_AW           5
`define BUF_MAX_LEN      6'h20

// Bus timing: quarter of a 400 kHz bit period
`define REF_CLK_MHZ      125
`define I2C_QUARTER_NS   625
`define I2C_QUARTER_CYC  ((`I2C_QUARTER_NS * `REF_CLK_MHZ + 999) / 1000)

`endif

// File: design/enc_ctl_pkg.sv
package enc_ctl_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] reg_addr_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_BIT   = 4'b0100,
    ST_STOP  = 4'b1000
  } i2c_state_t;

  typedef enum logic [4:0] {
    STG_ADDR  = 5'b00001,
    STG_SUB   = 5'b00010,
    STG_DATA  = 5'b00100,
    STG_RADDR = 5'b01000,
    STG_RDATA = 5'b10000
  } stage_t;

endpackage

// File: design/byte_mem_if.sv
`timescale 1ns/10ps
`include "enc_ctl_defines.svh"

interface byte_mem_if;
  logic                  wr_en;
  logic [`BUF_AW-1:0]    wr_addr;
  logic [7:0]            wr_data;
  logic [`BUF_AW-1:0]    rd_addr;
  logic [7:0]            rd_data;

  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// File: design/byte_mem.sv
`timescale 1ns/10ps
`include "enc_ctl_defines.svh"

module byte_mem (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Memory port
  byte_mem_if.mem   mem
);
  import enc_ctl_pkg::*;

  byte_t mem_ff [`BUF_DEPTH];
  byte_t rd_data_ff;

  always_ff @(posedge i_ref_clk) begin
    if (mem.wr_en) begin
      mem_ff[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Read data always lag the address by one edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= mem_ff[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_data_ff;
endmodule

// File: design/enc_i2c_host.sv
`timescale 1ns/10ps
`include "enc_ctl_defines.svh"
// Function
// - Colour write: COLOUR_TABLE_PORT, table address, RGB triplets
// - Line count entry at D0H: two bytes
// - Line pattern entry at D2H: eight bytes
// - Line type entry at D1H: four bytes
// - Value array entry: level byte, pulse byte
// - Sync table write starts with pointer byte
// - Load pattern array before line type array
// - After array read, reinitialise pointers before writing
// - Set both power-down bits in one write
// - Clear fast input cell bit before power-down
// - Line count: 4-bit type, 10-bit count
module enc_i2c_host (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  // Software register port
  input  wire enc_ctl_pkg::reg_addr_t i_addr,
  input  wire enc_ctl_pkg::byte_t     i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output enc_ctl_pkg::byte_t          o_rdata,
  output logic                        o_busy,
  // Bus pins, open drain
  input  wire logic                   i_scl,
  input  wire logic                   i_sda,
  output logic                        o_scl_out,
  output logic                        o_scl_oe,
  output logic                        o_sda_out,
  output logic                        o_sda_oe
);
  import enc_ctl_pkg::*;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  localparam logic [6:0] QEND = 7'(`I2C_QUARTER_CYC - 1);
  localparam byte_t      ADDR_WR = `DEV_ADDR_W;

  function automatic logic [3:0] ent_size(input byte_t sub);
    if (sub == `SUB_COLOUR) begin
      ent_size = `ENT_COLOUR;
    end else if (sub == `SUB_CURSOR) begin
      ent_size = `ENT_CURSOR;
    end else if (sub == `SUB_LINE_COUNT) begin
      ent_size = `ENT_COUNT;
    end else if (sub == `SUB_LINE_TYPE) begin
      ent_size = `ENT_TYPE;
    end else if (sub == `SUB_LINE_PAT) begin
      ent_size = `ENT_PAT;
    end else if (sub == `SUB_VALUE_ARR) begin
      ent_size = `ENT_VALUE;
    end else begin
      ent_size = 4'h0;
    end
  endfunction

  function automatic logic is_sync(input byte_t sub);
    is_sync = (sub >= `SUB_LINE_COUNT) && (sub <= `SUB_VALUE_ARR);
  endfunction

  // Pointer byte plus whole entries only
  function automatic logic len_ok(input byte_t sub, input logic [5:0] len);
    logic [3:0] sz;
    logic [5:0] n;
    sz = ent_size(sub);
    n  = len - 6'h01;
    if (len > `BUF_MAX_LEN) begin
      len_ok = 1'b0;
    end else if (sz == 4'h0) begin
      len_ok = 1'b1;
    end else if (len == 6'h00) begin
      len_ok = 1'b0;
    end else if (sz == `ENT_COLOUR) begin
      len_ok = (n % {2'h0, `ENT_COLOUR}) == 6'h00;
    end else begin
      len_ok = (n & {2'h0, sz - 4'h1}) == 6'h00;
    end
  endfunction

  byte_mem_if mem_bus ();

  byte_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .mem       (mem_bus)
  );

  logic [2:0]          scl_sync_ff;
  logic [2:0]          sda_sync_ff;
  logic                scl_in_ff;
  logic                sda_in_ff;
  logic [6:0]          qcnt_ff;
  i2c_state_t          state_ff;
  stage_t              stage_ff;
  logic [1:0]          phase_ff;
  logic [3:0]          bit_ff;
  logic [5:0]          byte_ff;
  logic                scl_oe_ff;
  logic                sda_oe_ff;
  byte_t               shift_ff;
  logic                nack_ff;
  logic                pd_seq_ff;
  logic                pd_up_ff;
  logic                pd_step_ff;
  logic                rd_op_ff;
  byte_t               sub_cur_ff;
  logic [5:0]          len_cur_ff;
  logic                pd_ff;
  byte_t               sub_ff;
  logic [5:0]          len_ff;
  logic [`BUF_AW-1:0]  buf_idx_ff;
  byte_t               fic_ff;
  byte_t               pwr_ff;
  byte_t               rdata_ff;
  logic                rd_buf_ff;
  logic                refused_ff;
  logic                pat_loaded_ff;
  logic                type_stale_ff;
  logic [3:0]          reinit_ff;
  logic                qtick;
  logic                adv;
  logic                rx_stage;
  logic                byte_last;
  logic                bit_drive;
  logic                eng_wr;
  byte_t               cur_byte;
  logic                cmd_wr;
  logic                want_wr;
  logic                want_rd;
  logic                want_pd;
  logic                want_pu;
  logic                ok_wr;
  logic                ok_rd;
  logic                accept;
  byte_t               pwr_mask;

  // Pin inputs: the second and third stage must agree before a change counts
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_in_ff   <= 1'b1;
      sda_in_ff   <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_in_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_in_ff <= sda_sync_ff[2];
      end
    end
  end

  // Quarter-bit tick; phase 2 waits while the slave stretches the clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || state_ff == ST_IDLE || qtick) begin
      qcnt_ff <= 7'h00;
    end else begin
      qcnt_ff <= qcnt_ff + 7'h01;
    end
  end

  assign qtick     = (qcnt_ff == QEND);
  assign adv       = qtick && !(phase_ff == 2'h2 && !scl_in_ff);
  assign rx_stage  = (stage_ff == STG_RDATA);
  assign byte_last = (byte_ff == len_cur_ff - 6'h01);
  assign pwr_mask  = byte_t'((1 << `PWR_ANALOG_BIT) | (1 << `PWR_DIGITAL_BIT));

  always_comb begin
    case (stage_ff)
      STG_ADDR:  cur_byte = `DEV_ADDR_W;
      STG_SUB:   cur_byte = sub_cur_ff;
      STG_RADDR: cur_byte = `DEV_ADDR_R;
      STG_RDATA: cur_byte = 8'hFF;
      default: begin
        if (!pd_seq_ff) begin
          cur_byte = mem_bus.rd_data;
        end else if (!pd_step_ff) begin
          cur_byte = fic_ff & ~byte_t'(1 << `FIC_BIT);
        end else if (pd_up_ff) begin
          cur_byte = pwr_ff & ~pwr_mask;
        end else begin
          cur_byte = pwr_ff | pwr_mask;
        end
      end
    endcase
  end

  // Data bits drive low for zero; the ack slot drives low on all but the last read byte
  always_comb begin
    if (!bit_ff[3]) begin
      bit_drive = !rx_stage && !cur_byte[~bit_ff[2:0]];
    end else begin
      bit_drive = rx_stage && !byte_last;
    end
  end

  assign eng_wr = (state_ff == ST_BIT) && rx_stage && adv && (phase_ff == 2'h3) && bit_ff[3];

  always_comb begin
    mem_bus.wr_en   = eng_wr || (i_wr && i_addr == `REG_BUF_DATA && state_ff == ST_IDLE);
    mem_bus.wr_addr = eng_wr ? byte_ff[`BUF_AW-1:0] : buf_idx_ff;
    mem_bus.wr_data = eng_wr ? shift_ff : i_wdata;
    mem_bus.rd_addr = (state_ff == ST_IDLE) ? buf_idx_ff : byte_ff[`BUF_AW-1:0];
  end

  // Command acceptance and its guards
  always_comb begin
    cmd_wr  = i_wr && (i_addr == `REG_CMD);
    want_wr = cmd_wr && i_wdata[`CMD_WR];
    want_rd = cmd_wr && i_wdata[`CMD_RD] && !want_wr;
    want_pd = cmd_wr && i_wdata[`CMD_PD] && !want_wr && !want_rd;
    want_pu = cmd_wr && i_wdata[`CMD_PU] && !want_wr && !want_rd && !want_pd;
    ok_wr   = !(pd_ff && ent_size(sub_ff) != 4'h0)
              && !(sub_ff == `SUB_LINE_TYPE && !pat_loaded_ff)
              && !(is_sync(sub_ff) && len_ff != 6'h01 && reinit_ff != 4'h0)
              && len_ok(sub_ff, len_ff);
    ok_rd   = !(pd_ff && ent_size(sub_ff) != 4'h0)
              && len_ff != 6'h00 && len_ff <= `BUF_MAX_LEN;
    accept  = (state_ff == ST_IDLE)
              && ((want_wr && ok_wr) || (want_rd && ok_rd) || want_pd || want_pu);
  end

  // Bus engine
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_ff   <= ST_IDLE;
      stage_ff   <= STG_ADDR;
      phase_ff   <= 2'h0;
      bit_ff     <= 4'h0;
      byte_ff    <= 6'h00;
      scl_oe_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
      shift_ff   <= 8'h00;
      nack_ff    <= 1'b0;
      pd_seq_ff  <= 1'b0;
      pd_up_ff   <= 1'b0;
      pd_step_ff <= 1'b0;
      rd_op_ff   <= 1'b0;
      sub_cur_ff <= 8'h00;
      len_cur_ff <= 6'h00;
      pd_ff      <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          phase_ff <= 2'h0;
          if (accept) begin
            state_ff   <= ST_START;
            stage_ff   <= STG_ADDR;
            nack_ff    <= 1'b0;
            rd_op_ff   <= want_rd;
            pd_seq_ff  <= want_pd || want_pu;
            pd_up_ff   <= want_pu;
            pd_step_ff <= want_pu;
            sub_cur_ff <= want_pd ? `SUB_FIC : (want_pu ? `SUB_PWR : sub_ff);
            len_cur_ff <= (want_pd || want_pu) ? 6'h01 : len_ff;
          end
        end
        ST_START: begin
          if (adv) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= 1'b0;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin
                scl_oe_ff <= 1'b1;
                bit_ff    <= 4'h0;
                state_ff  <= ST_BIT;
                // Repeated start after the subaddress keeps the read pointer
                stage_ff  <= (stage_ff == STG_SUB) ? STG_RADDR : STG_ADDR;
              end
            endcase
          end
        end
        ST_BIT: begin
          if (adv) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= bit_drive;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: begin
                if (!bit_ff[3]) begin
                  shift_ff <= {shift_ff[6:0], sda_in_ff};
                end else if (!rx_stage && sda_in_ff) begin
                  nack_ff <= 1'b1;
                end
              end
              default: begin
                scl_oe_ff <= 1'b1;
                if (!bit_ff[3]) begin
                  bit_ff <= bit_ff + 4'h1;
                end else begin
                  bit_ff <= 4'h0;
                  if (nack_ff) begin
                    state_ff <= ST_STOP;
                  end else begin
                    case (stage_ff)
                      STG_ADDR: stage_ff <= STG_SUB;
                      STG_SUB: begin
                        if (rd_op_ff) begin
                          state_ff <= ST_START;
                        end else if (len_cur_ff == 6'h00) begin
                          state_ff <= ST_STOP;
                        end else begin
                          stage_ff <= STG_DATA;
                          byte_ff  <= 6'h00;
                        end
                      end
                      STG_RADDR: begin
                        stage_ff <= STG_RDATA;
                        byte_ff  <= 6'h00;
                      end
                      default: begin
                        if (byte_last) begin
                          state_ff <= ST_STOP;
                        end else begin
                          byte_ff <= byte_ff + 6'h01;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (adv) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sda_oe_ff <= 1'b1;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin
                // Input-cell byte goes out in its own transfer ahead of the power byte
                if (pd_seq_ff && !pd_step_ff && !nack_ff) begin
                  state_ff   <= ST_START;
                  stage_ff   <= STG_ADDR;
                  pd_step_ff <= 1'b1;
                  sub_cur_ff <= `SUB_PWR;
                end else begin
                  state_ff  <= ST_IDLE;
                  pd_seq_ff <= 1'b0;
                  if (pd_seq_ff && !nack_ff) begin
                    pd_ff <= !pd_up_ff;
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Software-visible settings
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sub_ff     <= 8'h00;
      len_ff     <= 6'h00;
      buf_idx_ff <= '0;
      fic_ff     <= 8'h00;
      pwr_ff     <= 8'h00;
    end else if (i_wr) begin
      if (i_addr == `REG_SUB) begin
        sub_ff <= i_wdata;
      end else if (i_addr == `REG_LEN) begin
        len_ff <= i_wdata[5:0];
      end else if (i_addr == `REG_BUF_IDX) begin
        buf_idx_ff <= i_wdata[`BUF_AW-1:0];
      end else if (i_addr == `REG_BUF_DATA && state_ff == ST_IDLE) begin
        buf_idx_ff <= buf_idx_ff + `BUF_AW'(1'b1);
      end else if (i_addr == `REG_FIC) begin
        fic_ff <= i_wdata;
      end else if (i_addr == `REG_PWR) begin
        pwr_ff <= i_wdata;
      end
    end else if (i_rd && i_addr == `REG_BUF_DATA && state_ff == ST_IDLE) begin
      buf_idx_ff <= buf_idx_ff + `BUF_AW'(1'b1);
    end
  end

  // Table-order bookkeeping and refusal status
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      refused_ff    <= 1'b0;
      pat_loaded_ff <= 1'b0;
      type_stale_ff <= 1'b0;
      reinit_ff     <= 4'h0;
    end else begin
      if (want_wr || want_rd || want_pd || want_pu) begin
        refused_ff <= !accept;
      end
      if (accept && want_wr && sub_ff == `SUB_LINE_PAT) begin
        pat_loaded_ff <= 1'b1;
        type_stale_ff <= 1'b1;
      end else if (accept && want_wr && sub_ff == `SUB_LINE_TYPE) begin
        type_stale_ff <= 1'b0;
      end
      if (accept && want_rd && is_sync(sub_ff)) begin
        reinit_ff <= 4'hF;
      end else if (accept && want_wr && is_sync(sub_ff) && len_ff == 6'h01) begin
        reinit_ff[sub_ff[1:0]] <= 1'b0;
      end
    end
  end

  // Register read port; buffer data come straight from the memory's output register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rdata_ff  <= 8'h00;
      rd_buf_ff <= 1'b0;
    end else begin
      rd_buf_ff <= i_rd && (i_addr == `REG_BUF_DATA) && (state_ff == ST_IDLE);
      if (!i_rd) begin
        rdata_ff <= 8'h00;
      end else if (i_addr == `REG_SUB) begin
        rdata_ff <= sub_ff;
      end else if (i_addr == `REG_LEN) begin
        rdata_ff <= {2'h0, len_ff};
      end else if (i_addr == `REG_STATUS) begin
        rdata_ff <= {1'b0, pat_loaded_ff, pd_ff, reinit_ff != 4'h0, type_stale_ff,
                     refused_ff, nack_ff, state_ff != ST_IDLE};
      end else if (i_addr == `REG_BUF_IDX) begin
        rdata_ff <= {{(8-`BUF_AW){1'b0}}, buf_idx_ff};
      end else if (i_addr == `REG_FIC) begin
        rdata_ff <= fic_ff;
      end else if (i_addr == `REG_PWR) begin
        rdata_ff <= pwr_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign o_rdata   = rd_buf_ff ? mem_bus.rd_data : rdata_ff;
  assign o_busy    = (state_ff != ST_IDLE);
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe  = scl_oe_ff;
  assign o_sda_oe  = sda_oe_ff;

  a_addr_write: assert property (
    (state_ff == ST_BIT && stage_ff == STG_ADDR && phase_ff == 2'h1 && !bit_ff[3])
      |-> (sda_oe_ff == !ADDR_WR[~bit_ff[2:0]])
  ) else $error("address bit on the wire differs from the write address");

  a_addr_read: assert property (
    (state_ff == ST_START && adv && phase_ff == 2'h3 && stage_ff == STG_SUB)
      |=> (stage_ff == STG_RADDR && cur_byte == `DEV_ADDR_R)
  ) else $error("repeated start not followed by the read address");

  a_pd_table: assert property (
    (want_wr && pd_ff && ent_size(sub_ff) != 4'h0)
      |=> (state_ff == ST_IDLE && refused_ff)
  ) else $error("table write accepted in power-down");

  a_type_order: assert property (
    (accept && want_wr && sub_ff == `SUB_LINE_TYPE) |-> pat_loaded_ff
  ) else $error("line type write before pattern load");

  a_reinit_gate: assert property (
    (accept && want_wr && is_sync(sub_ff) && len_ff != 6'h01) |-> (reinit_ff == 4'h0)
  ) else $error("sync write accepted before pointer reinit");

  a_colour_len: assert property (
    (accept && want_wr && sub_ff == `SUB_COLOUR)
      |-> ((len_ff - 6'h01) % 6'h03 == 6'h00 && len_ff != 6'h00)
  ) else $error("colour write not a whole number of triplets");

  a_pd_both: assert property (
    (state_ff == ST_BIT && stage_ff == STG_DATA && pd_seq_ff && pd_step_ff && !pd_up_ff)
      |-> (cur_byte[`PWR_ANALOG_BIT] && cur_byte[`PWR_DIGITAL_BIT])
  ) else $error("power-down byte lacks one of the two bits");

  a_fic_first: assert property (
    (accept && want_pd) |=> (sub_cur_ff == `SUB_FIC && !pd_step_ff)
      ##1 (!cur_byte[`FIC_BIT] || stage_ff != STG_DATA)
  ) else $error("power-down did not start with the input-cell byte");

  a_fic_clear: assert property (
    (state_ff == ST_BIT && stage_ff == STG_DATA && pd_seq_ff && !pd_step_ff)
      |-> !cur_byte[`FIC_BIT]
  ) else $error("input-cell byte still has the fast bit set");

  a_sub_follows: assert property (
    (state_ff == ST_BIT && stage_ff == STG_ADDR && bit_ff[3] && adv && phase_ff == 2'h3
     && !nack_ff) |=> (stage_ff == STG_SUB && cur_byte == sub_cur_ff)
  ) else $error("subaddress byte does not follow the address");
endmodule

// File: bench/enc_dev_model.sv
`timescale 1ns/10ps
module enc_dev_model (
  // Bus wires
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] sub;
  int         n;
  int         st = -1;
  // Set by the bench to make the device ignore its own address
  logic       mute = 1'b0;
  initial begin
    o_sda_oe = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Repeated start keeps sub, so a read resumes where the write left off
  always @(negedge i_sda) if (i_scl) begin
    n = 0;
    st = 0;
  end
  always @(posedge i_sda) if (i_scl) st = -1;
  always @(posedge i_scl) if (st >= 0) begin
    if (n < 8 && st != 4) sh = {sh[6:0], i_sda};
    if (n == 8 && st == 4 && i_sda) st = -1;
    n++;
  end
  always @(negedge i_scl) if (st >= 0) begin
    o_sda_oe <= 1'b0;
    if (n == 8 && st == 0) begin
      st = (!mute && sh[7:1] == 7'h44) ? (sh[0] ? 4 : 1) : -1;
      o_sda_oe <= (st > 0);
    end else if (n == 8 && st < 4) begin
      if (st == 1) sub = sh;
      else if (sub > 8'h01) mem[sub] = sh;
      if (st == 2) sub++;
      st = 2;
      o_sda_oe <= 1'b1;
    end
    if (n == 9) begin
      n = 0;
      if (st == 4) sh = mem[sub];
      if (st == 4) sub++;
    end
    if (st == 4 && n < 8) o_sda_oe <= !sh[7 - n];
  end
endmodule

// File: bench/encoder_control_port_tables_test.sv
`timescale 1ns/10ps
`include "enc_ctl_defines.svh"
module encoder_control_port_tables_test;
  import enc_ctl_pkg::*;
  logic      clk = 0, rstn = 0, wr = 0, rd = 0, busy, scl_oe, sda_oe, dev_oe;
  logic      scl_out, sda_out;
  reg_addr_t addr = '0;
  byte_t     wdata = '0, rdata, got;
  int        fails = 0, cmp_count = 0, cyc = 0;
  wire       scl = !scl_oe;
  wire       sda = !(sda_oe | dev_oe);
  typedef struct {reg_addr_t a; byte_t d; byte_t e;} row_t;
  row_t rows[4] = '{'{`REG_SUB, 8'h5A, 8'h5A}, '{`REG_LEN, 8'hFF, 8'h3F},
                    '{`REG_BUF_IDX, 8'hFF, 8'h1F}, '{4'hC, 8'h77, 8'h00}};
  always #4 clk = !clk;
  enc_i2c_host dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_busy(busy), .i_scl(scl), .i_sda(sda),
    .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out), .o_sda_oe(sda_oe));
  enc_dev_model dev (.i_scl(scl), .i_sda(sda), .o_sda_oe(dev_oe));
  task wreg(input reg_addr_t a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input reg_addr_t a, output byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task chk(input byte_t g, input byte_t e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input byte_t c);
    wreg(`REG_CMD, c);
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task conclude;
    $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs about 68k cycles of bus traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rreg(`REG_STATUS, got);
    chk(got, 8'h00);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, got);
      chk(got, rows[i].e);
    end
    wreg(`REG_SUB, 8'h10);
    wreg(`REG_LEN, 8'h02);
    wreg(`REG_BUF_IDX, 8'h00);
    wreg(`REG_BUF_DATA, 8'hA5);
    wreg(`REG_BUF_DATA, 8'h3C);
    xfer(8'h01);
    chk(dev.mem[8'h10], 8'hA5);
    chk(dev.mem[8'h11], 8'h3C);
    dev.mem[8'h10] = 8'h96;
    xfer(8'h02);
    wreg(`REG_BUF_IDX, 8'h00);
    rreg(`REG_BUF_DATA, got);
    chk(got, 8'h96);
    rreg(`REG_BUF_DATA, got);
    chk(got, 8'h3C);
    wreg(`REG_SUB, `SUB_LINE_TYPE);
    wreg(`REG_LEN, 8'h05);
    xfer(8'h01);
    rreg(`REG_STATUS, got);
    chk(got, 8'h04);
    dev.mem[`SUB_FIC] = 8'hFF;
    wreg(`REG_FIC, 8'h5B);
    wreg(`REG_PWR, 8'h21);
    xfer(8'h04);
    chk(dev.mem[`SUB_FIC], 8'h5A);
    chk(dev.mem[`SUB_PWR], 8'hE1);
    wreg(`REG_SUB, `SUB_COLOUR);
    wreg(`REG_LEN, 8'h04);
    xfer(8'h01);
    rreg(`REG_STATUS, got);
    chk(got, 8'h24);
    chk({6'h00, scl_out, sda_out}, 8'h00);
    dev.mute = 1'b1;
    wreg(`REG_SUB, 8'h10);
    wreg(`REG_LEN, 8'h01);
    xfer(8'h01);
    rreg(`REG_STATUS, got);
    chk(got, 8'h22);
    dev.mute = 1'b0;
    xfer(8'h08);
    chk(dev.mem[`SUB_PWR], 8'h21);
    rreg(`REG_STATUS, got);
    chk(got, 8'h00);
    wreg(`REG_SUB, `SUB_LINE_COUNT);
    wreg(`REG_LEN, 8'h04);
    xfer(8'h01);
    rreg(`REG_STATUS, got);
    chk(got, 8'h04);
    wreg(`REG_BUF_IDX, 8'h00);
    wreg(`REG_BUF_DATA, 8'h00);
    dev.mem[`SUB_LINE_PAT] = 8'hFF;
    wreg(`REG_SUB, `SUB_LINE_PAT);
    wreg(`REG_LEN, 8'h01);
    xfer(8'h01);
    chk(dev.mem[`SUB_LINE_PAT], 8'h00);
    rreg(`REG_STATUS, got);
    chk(got, 8'h48);
    wreg(`REG_SUB, `SUB_LINE_TYPE);
    wreg(`REG_LEN, 8'h06);
    xfer(8'h01);
    rreg(`REG_STATUS, got);
    chk(got, 8'h4C);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(`REG_STATUS, got);
    chk(got, 8'h00);
    rreg(`REG_SUB, got);
    chk(got, 8'h00);
    conclude();
  end
endmodule
